/* File: pfc_cache.sv */
module pfc_cache (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// CPU fetch port
	input wire logic cpu_req,
	input wire logic cpu_is_data,
	input wire logic [pfc_pkg::ADDR_W-1:0] cpu_addr,
	output logic cpu_ack,
	output logic [pfc_pkg::WORD_W-1:0] cpu_rdata,
	// Wait-state option
	input wire logic ws_manual,
	input wire logic [pfc_pkg::WS_W-1:0] ws_count,
	// Array port
	output logic arr_req,
	output logic [pfc_pkg::ADDR_W-1:0] arr_addr,
	input wire logic [pfc_pkg::WORD_W-1:0] arr_rdata
);
	localparam int unsigned TW = pfc_pkg::TAG_W;
	localparam int unsigned WW = pfc_pkg::WORD_W;

	logic [pfc_pkg::LINE_W-1:0] line_q [pfc_pkg::WAYS];
	logic [TW-1:0] tag_q [pfc_pkg::WAYS];
	logic [pfc_pkg::WAYS-1:0] valid_q;
	logic victim_q;
	logic fill_way_q;
	logic [1:0] word_q;
	logic [TW-1:0] fill_tag_q;
	pfc_pkg::state_e state_q;
	logic pace_done;
	logic pace_start;
	logic [pfc_pkg::WS_W-1:0] waits;
	logic [TW-1:0] req_tag;
	logic [1:0] req_word;
	logic hit0;
	logic hit1;
	logic hit;
	logic take;
	logic take_data;
	logic take_hit;
	logic take_miss;
	logic fill_step;
	logic fill_last;
	logic fill_next;
	logic data_done;

	// Word select, address and tag match helpers
	function automatic logic [WW-1:0] pick(input logic [pfc_pkg::LINE_W-1:0] l, input logic [1:0] w);
		pick = l[w*WW +: WW];
	endfunction

	function automatic logic [pfc_pkg::ADDR_W-1:0] word_addr(input logic [TW-1:0] t, input logic [1:0] w);
		word_addr = {t, w, 1'b0};
	endfunction

	function automatic logic way_match(input logic v, input logic [TW-1:0] t, input logic [TW-1:0] r);
		way_match = v && t == r;
	endfunction

	assign req_tag = cpu_addr[pfc_pkg::ADDR_W-1:3];
	assign req_word = cpu_addr[2:1];
	assign hit0 = way_match(valid_q[0], tag_q[0], req_tag);
	assign hit1 = way_match(valid_q[1], tag_q[1], req_tag);
	assign hit = hit0 || hit1;
	// Request decode shared by the blocks below, except the replacement block
	assign take = state_q == pfc_pkg::ST_IDLE && cpu_req && !cpu_ack;
	assign take_data = take && cpu_is_data;
	assign take_hit = take && !cpu_is_data && hit;
	assign take_miss = take && !cpu_is_data && !hit;
	assign fill_step = state_q == pfc_pkg::ST_FILL && pace_done;
	assign fill_last = fill_step && word_q == 2'h3;
	assign fill_next = fill_step && !fill_last;
	assign data_done = state_q == pfc_pkg::ST_DATA && pace_done;
	assign waits = ws_manual ? ws_count : pfc_pkg::WS_AUTO;
	assign pace_start = arr_req;

	pfc_pace u_pace (
		.mclk(mclk),
		.rst(rst),
		.start(pace_start),
		.waits(waits),
		.done(pace_done)
	);

	// Sequencer: idle, line fill or data pass-through
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			state_q <= pfc_pkg::ST_IDLE;
		else
		begin
			unique case (state_q)
				pfc_pkg::ST_IDLE:
				begin
					if (take_data)
						state_q <= pfc_pkg::ST_DATA;
					else if (take_miss)
						state_q <= pfc_pkg::ST_FILL;
				end
				pfc_pkg::ST_FILL:
				begin
					if (fill_last)
						state_q <= pfc_pkg::ST_IDLE;
				end
				pfc_pkg::ST_DATA:
				begin
					if (pace_done)
						state_q <= pfc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Answers to the CPU, one-cycle acknowledge
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cpu_ack <= 1'b0;
			cpu_rdata <= '0;
		end
		else
		begin
			cpu_ack <= take_hit || data_done;
			if (take_hit)
				cpu_rdata <= pick(hit0 ? line_q[0] : line_q[1], req_word);
			else if (data_done)
				cpu_rdata <= arr_rdata;
		end
	end

	// Array word requests, one per paced access
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			arr_req <= 1'b0;
			arr_addr <= '0;
		end
		else
		begin
			arr_req <= take_data || take_miss || fill_next;
			if (take_data)
				arr_addr <= cpu_addr;
			else if (take_miss)
				arr_addr <= word_addr(req_tag, 2'h0);
			else if (fill_next)
				arr_addr <= word_addr(fill_tag_q, word_q + 2'h1);
		end
	end

	// Fill target, tag and word position
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			word_q <= 2'h0;
			fill_way_q <= 1'b0;
			fill_tag_q <= '0;
		end
		else if (take_miss)
		begin
			word_q <= 2'h0;
			fill_way_q <= victim_q;
			fill_tag_q <= req_tag;
		end
		else if (fill_next)
			word_q <= word_q + 2'h1;
	end

	// Line data, one word per paced array access
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < pfc_pkg::WAYS; i++)
			begin
				line_q[i] <= '0;
			end
		end
		else if (fill_step)
		begin
			line_q[fill_way_q][word_q*WW +: WW] <= arr_rdata;
		end
	end

	// Tags and valid flags; a way is dropped before its refill
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			valid_q <= '0;
			for (int i = 0; i < pfc_pkg::WAYS; i++)
			begin
				tag_q[i] <= '0;
			end
		end
		else if (take_miss)
		begin
			valid_q[victim_q] <= 1'b0;
		end
		else if (fill_last)
		begin
			valid_q[fill_way_q] <= 1'b1;
			tag_q[fill_way_q] <= fill_tag_q;
		end
	end

	// Replacement keeps the page in use and refills the other
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			victim_q <= 1'b0;
		else if (state_q == pfc_pkg::ST_IDLE && cpu_req && !cpu_ack && !cpu_is_data)
		begin
			if (hit)
				victim_q <= hit0;
			else
				victim_q <= ~victim_q;
		end
	end
endmodule

/* File: pfc_pkg.sv */
package pfc_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned LINE_W = 64;
	localparam int unsigned WORDS_PER_LINE = 4;
	localparam int unsigned WAYS = 2;
	localparam int unsigned TAG_W = ADDR_W - 3;
	localparam int unsigned WS_W = 4;
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned ARRAY_MAX_HZ = 8000000;
	// Least array access period in cycles, rounded up
	localparam int unsigned ARRAY_CYCLES = (CLK_HZ + ARRAY_MAX_HZ - 1) / ARRAY_MAX_HZ;
	localparam logic [WS_W-1:0] WS_AUTO = 4'(ARRAY_CYCLES - 1);
	localparam logic [WS_W-1:0] WS_RESET = 4'h0;
	typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_DATA} state_e;
endpackage

/* File: pfc_pace.sv */
module pfc_pace (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Control
	input wire logic start,
	input wire logic [pfc_pkg::WS_W-1:0] waits,
	// Access done pulse
	output logic done
);
	logic [pfc_pkg::WS_W-1:0] cnt_q;
	logic busy_q;

	// Paces each array word to at least the minimum access period
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= pfc_pkg::WS_RESET;
			busy_q <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start && !busy_q)
			begin
				busy_q <= 1'b1;
				cnt_q <= (waits < pfc_pkg::WS_AUTO) ? pfc_pkg::WS_AUTO : waits;
			end
			else if (busy_q)
			begin
				if (cnt_q == pfc_pkg::WS_RESET)
				begin
					busy_q <= 1'b0;
					done <= 1'b1;
				end
				else
					cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule

/* File: pfc_cache_properties.sv */
module pfc_cache_chk (
	// Watched ports
	input wire logic mclk,
	input wire logic rst,
	input wire logic cpu_req,
	input wire logic cpu_is_data,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_ack,
	input wire logic [15:0] cpu_rdata,
	input wire logic ws_manual,
	input wire logic [3:0] ws_count,
	input wire logic arr_req,
	input wire logic [15:0] arr_addr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_fill; $rose(cpu_req) && !cpu_is_data && !ws_manual ##1 arr_req; endsequence
	sequence s_rd; $rose(cpu_req) && cpu_is_data; endsequence
	property p_rate; arr_req |=> !arr_req [*6]; endproperty
	a_rate: assert property (p_rate) else $error("array rate");
	property p_four; s_fill |-> ##9 arr_req ##9 arr_req ##9 arr_req ##[8:11] cpu_ack; endproperty
	a_four: assert property (p_four) else $error("fill");
	property p_line; s_fill |-> arr_addr == {cpu_addr[15:3], 3'h0}; endproperty
	a_line: assert property (p_line) else $error("line");
	property p_data; (s_rd and !ws_manual) |=> arr_req ##9 cpu_ack; endproperty
	a_data: assert property (p_data) else $error("data");
	property p_man; (s_rd and (ws_manual && ws_count == 4'hF)) |-> ##19 cpu_ack; endproperty
	a_man: assert property (p_man) else $error("manual");
	property p_low; (s_rd and (ws_manual && ws_count == 4'h2)) |-> ##10 cpu_ack; endproperty
	a_low: assert property (p_low) else $error("low");
	property p_ack; cpu_ack |-> !arr_req ##1 !cpu_ack; endproperty
	a_ack: assert property (p_ack) else $error("ack");
	property p_hold; !cpu_ack |-> $stable(cpu_rdata); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_quick; $rose(cpu_req) && !cpu_is_data |=> cpu_ack || arr_req; endproperty
	a_quick: assert property (p_quick) else $error("fetch answer");
endmodule
bind pfc_cache pfc_cache_chk chk (.mclk, .rst, .cpu_req, .cpu_is_data, .cpu_addr, .cpu_ack, .cpu_rdata,
	.ws_manual, .ws_count, .arr_req, .arr_addr);

/* File: pfc_array.sv */
module pfc_array (
	// Array port
	input wire logic mclk,
	input wire logic arr_req,
	input wire logic [15:0] arr_addr,
	output logic [15:0] arr_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] a_q = 16'h0000;
	logic [2:0] age_q = 3'h0;
	always @(posedge mclk)
	begin
		if (arr_req)
		begin
			a_q <= arr_addr;
			age_q <= 3'h0;
		end
		else if (age_q != 3'h7)
			age_q <= age_q + 3'h1;
	end
	// Garbage until access time passes
	assign arr_rdata = (age_q >= 3'h5) ? a_q ^ 16'hC3A5 : ~(a_q ^ 16'hC3A5);
endmodule

/* File: nvm_instruction_prefetch_cache_bench.sv */
module nvm_instruction_prefetch_cache_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic cpu_req = 1'b0;
	logic cpu_is_data = 1'b0;
	logic ws_manual = 1'b0;
	logic [15:0] cpu_addr = 16'h0000;
	logic [3:0] ws_count = 4'h0;
	logic cpu_ack;
	logic arr_req;
	logic [15:0] cpu_rdata;
	logic [15:0] arr_rdata;
	logic [15:0] arr_addr;
	int error_cnt = 0;
	int n_checks = 0;
	pfc_cache dut (.mclk, .rst, .cpu_req, .cpu_is_data, .cpu_addr, .cpu_ack, .cpu_rdata,
		.ws_manual, .ws_count, .arr_req, .arr_addr, .arr_rdata);
	pfc_array mem (.mclk, .arr_req, .arr_addr, .arr_rdata);
	initial
	begin
		forever #10 mclk = ~mclk;
	end
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task complete_run;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Negative latency means a fill with wait states
	task fetch(input logic dat, input logic [15:0] a, input int lat);
		int n;
		n = 0;
		@(negedge mclk);
		cpu_req = 1'b1;
		cpu_is_data = dat;
		cpu_addr = a;
		while (cpu_ack !== 1'b1 && n < 60)
		begin
			@(negedge mclk);
			n++;
		end
		if (cpu_ack !== 1'b1)
		begin
			error_cnt++;
			complete_run;
		end
		cpu_req = 1'b0;
		check("rdata", cpu_rdata, a ^ 16'hC3A5);
		if (lat < 0)
			check("wait", 16'(n > 30), 16'h0001);
		else
			check("latency", 16'(n), 16'(lat));
	endtask
	task t_fill_hit;
		fetch(1'b0, 16'h0106, -1);
		fetch(1'b0, 16'h0100, 1);
		fetch(1'b0, 16'h0104, 1);
		$display("fill_hit done");
	endtask
	task t_two_ways;
		fetch(1'b0, 16'h2A08, -1);
		fetch(1'b0, 16'h0102, 1);
		fetch(1'b0, 16'h2A0E, 1);
		$display("two_ways done");
	endtask
	task t_refill;
		fetch(1'b0, 16'h7F10, -1);
		fetch(1'b0, 16'h2A0A, 1);
		fetch(1'b0, 16'h0100, -1);
		$display("refill done");
	endtask
	task t_data;
		fetch(1'b1, 16'h2A08, 10);
		ws_manual = 1'b1;
		ws_count = 4'hF;
		fetch(1'b1, 16'h0040, 19);
		ws_count = 4'h2;
		fetch(1'b1, 16'h0042, 10);
		ws_manual = 1'b0;
		$display("data done");
	endtask
	initial
	begin
		repeat (5) @(negedge mclk);
		rst = 1'b0;
		t_fill_hit;
		t_two_ways;
		t_refill;
		t_data;
		complete_run;
	end
endmodule
